// ---- hdl/rwcm_pkg.sv ----
/*
 * Constants of the reset, watchdog and clock-fail monitor block.
 * Register offsets, option field positions, reset values, timing counts
 * and reset vectors. Assumes a 100 MHz bus clock.
 */
package rwcm_pkg;
	// Register offsets on the plain register port
	localparam logic [7:0] OFF_SYSTEM_OPTIONS = 8'h39; // Options register
	localparam logic [7:0] OFF_WATCHDOG_SERVICE = 8'h3a; // Service register, write only
	localparam logic [7:0] OFF_RESET_STATUS = 8'h3d; // Cause and state readback
	localparam logic [7:0] OFF_TEST_CONTROL = 8'h3e; // Test control register

	// Option register field positions
	localparam int OPT_CONV_POWER = 7; // Converter power up
	localparam int OPT_CONV_CLKSEL = 6; // Converter clock select
	localparam int OPT_IRQ_EDGE = 5; // IRQ falling edge select
	localparam int OPT_STOP_DLY = 4; // STOP exit delay enable
	localparam int OPT_CFD_EN = 3; // Clock fail detect enable
	localparam int OPT_CFD_FORCE = 2; // Forced clock fail detect
	localparam int OPT_RATE_HI = 1; // Watchdog rate select high bit
	localparam int OPT_RATE_LO = 0; // Watchdog rate select low bit
	localparam int TST_INHIBIT = 0; // Reset inhibit test bit position

	// Reset values
	localparam logic [7:0] OPT_RESET = 8'h10; // Options after reset
	localparam logic TST_INHIBIT_RESET = 1'h1; // Watchdog resets start inhibited in special mode

	// Service codes
	localparam logic [7:0] SVC_ARM = 8'h55; // Arms the clear
	localparam logic [7:0] SVC_CLEAR = 8'haa; // Clears the timer when armed

	// Timing counts in bus clock cycles
	localparam logic [11:0] POR_WAIT_CYC = 12'hfe0; // 4064 cycles after oscillator starts
	localparam logic [11:0] PIN_DRIVE_CYC = 12'h004; // Reset pin driven low
	localparam logic [11:0] PIN_SETTLE_CYC = 12'h002; // Wait before sampling pin
	localparam logic [11:0] SYNC_DELAY_CYC = 12'h002; // Two-flop pin synchroniser lag
	localparam logic [6:0] PROT_WINDOW_CYC = 7'h40; // 64-cycle protected write window
	localparam logic [11:0] STOP_DLY_CYC = 12'hfa0; // 4000-cycle STOP exit delay
	localparam int WD_PRESCALE_BITS = 15; // Bus clock divided by 2^15

	// Reset causes
	localparam logic [1:0] CAUSE_NORMAL = 2'h0; // Power-on or pin
	localparam logic [1:0] CAUSE_CLKFAIL = 2'h1; // Clock fail monitor
	localparam logic [1:0] CAUSE_WATCHDOG = 2'h2; // Watchdog timeout

	// Reset vectors, normal and special modes
	localparam logic [15:0] VEC_NORMAL = 16'hfffe; // Power-on or pin, normal
	localparam logic [15:0] VEC_CLKFAIL = 16'hfffc; // Clock fail, normal
	localparam logic [15:0] VEC_WATCHDOG = 16'hfffa; // Watchdog, normal
	localparam logic [15:0] VEC_SP_NORMAL = 16'hbffe; // Power-on or pin, special
	localparam logic [15:0] VEC_SP_CLKFAIL = 16'hbffc; // Clock fail, special
	localparam logic [15:0] VEC_SP_WATCHDOG = 16'hbffa; // Watchdog, special

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_POR = 6'h01,
		ST_RUN = 6'h02,
		ST_DRIVE = 6'h04,
		ST_SETTLE = 6'h08,
		ST_HOLD = 6'h10,
		ST_SPARE = 6'h20
	} rwcm_state_e;
endpackage : rwcm_pkg

// ---- hdl/rwcm_wdog.sv ----
/*
 * Watchdog timer: free running 2^15 prescaler, then a rate scaler.
 * Assumes clear and reset come from logic on clk_sys.
 */
`timescale 1ns/100ps
module rwcm_wdog (
	input wire logic clk_sys, // Bus clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic sys_reset, // Reset sequence in progress
	input wire logic enable, // Watchdog may fire
	input wire logic [1:0] rate, // Rate select code
	input wire logic clear, // Service completed, one cycle
	output logic timeout // Expiry pulse, registered
);
	////////////////////////////////////////////////////////////////////
	logic [rwcm_pkg::WD_PRESCALE_BITS-1:0] pre_reg; // Free running prescaler
	logic [6:0] tick_cnt_reg; // Prescaled ticks since last clear
	logic tick; // One-cycle prescaled tick

	// Divide factor for a rate code
	function automatic logic [6:0] rate_limit(input logic [1:0] code);
		case (code)
			2'h0: rate_limit = 7'h01;
			2'h1: rate_limit = 7'h04;
			2'h2: rate_limit = 7'h10;
			default: rate_limit = 7'h40;
		endcase
	endfunction : rate_limit

	assign tick = &pre_reg;

	// Prescaler never stops; a clear does not realign it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// Expire on the tick after the limit: nominal to nominal plus one tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
			timeout <= 1'b0;
		end else if (sys_reset || clear || !enable) begin
			tick_cnt_reg <= '0;
			timeout <= 1'b0;
		end else if (tick) begin
			if (tick_cnt_reg == rate_limit(rate)) begin
				timeout <= 1'b1;
				tick_cnt_reg <= '0;
			end else begin
				timeout <= 1'b0;
				tick_cnt_reg <= tick_cnt_reg + 7'h01;
			end
		end else begin
			timeout <= 1'b0;
		end
	end
endmodule : rwcm_wdog

// ---- hdl/rwcm_clkmon.sv ----
/*
 * Clock fail monitor flag. Sets without any clock edge from the
 * analog RC stale detector. Assumes rc_stale rises when no bus clock
 * edge has been seen within the RC delay.
 */
`timescale 1ns/100ps
module rwcm_clkmon (
	input wire logic clk_sys, // Bus clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic rc_stale, // RC detector: clock missing or slow
	input wire logic stop_mode, // CPU entering or in STOP
	input wire logic enable, // Monitor enabled
	input wire logic ack, // Sequencer took the failure
	output logic fail // Failure flag
);
	////////////////////////////////////////////////////////////////////
	logic fail_set; // Asynchronous set request

	// STOP halts the clock, so an enabled monitor fails on it at once
	assign fail_set = enable & (rc_stale | stop_mode);

	// Preset path needs no clock; the set outranks the acknowledge
	always_ff @(posedge clk_sys or negedge rst_n or posedge fail_set) begin
		if (!rst_n) begin
			fail <= 1'b0;
		end else if (fail_set) begin
			fail <= 1'b1;
		end else if (ack) begin
			fail <= 1'b0;
		end
	end
endmodule : rwcm_clkmon

// ---- hdl/rwcm_top.sv ----
/*
 * Reset sequencer, option register, watchdog service and clock fail
 * monitor control. Assumes one 100 MHz bus clock, a reset pin seen
 * through separate in/out/enable signals, and a register master that
 * issues single-cycle strobes.
 */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module rwcm_top (
	input wire logic clk_sys, // Bus clock, 100 MHz
	input wire logic rst_n, // Power-on reset, asynchronous, active low
	input wire logic osc_running, // Oscillator running, from pin domain
	input wire logic reset_pin_in, // Reset pin level
	output logic reset_pin_out, // Reset pin drive value, always low
	output logic reset_pin_oe, // Reset pin drive enable
	input wire logic special_mode, // Test or bootstrap mode strap
	input wire logic watchdog_disable_bit, // Nonvolatile configuration latch
	input wire logic irq_n, // IRQ pin, active low
	input wire logic stop_mode, // CPU in STOP, same clock
	input wire logic stop_exit_req, // STOP wake-up pulse
	input wire logic rc_stale, // RC detector, no recent clock
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, one cycle after strobe
	output logic cpu_reset, // Holds the CPU in reset
	output logic [15:0] reset_vector, // Vector address for the fetch
	output logic irq_request, // IRQ request to the CPU
	output logic stop_exit_ready, // STOP exit may proceed, pulse
	output logic converter_power_up, // Converter power enable
	output logic converter_clock_select, // Converter clock from RC
	output logic [1:0] last_cause // Cause of last reset
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic [3:0] sync1_reg; // First synchroniser stage
	logic [3:0] sync2_reg; // Second synchroniser stage
	logic pin_s; // Synchronised reset pin
	logic osc_s; // Synchronised oscillator running
	logic irq_s; // Synchronised IRQ pin
	logic special_s; // Synchronised mode strap
	logic irq_q_reg; // IRQ one cycle late for edges
	rwcm_pkg::rwcm_state_e state_reg; // Sequencer state
	logic [11:0] seq_cnt_reg; // Sequencer cycle counter
	logic [1:0] cause_reg; // Pending or last cause
	logic [7:0] option_reg; // System options register
	logic inhibit_reg; // Reset inhibit test bit
	logic wd_disable_reg; // Latched watchdog disable
	logic arm_reg; // Service armed by 55
	logic [6:0] win_cnt_reg; // Cycles since reset release
	logic prot_done_reg; // Protected bits already written
	logic [11:0] stop_cnt_reg; // STOP exit delay counter
	logic stop_wait_reg; // STOP exit delay running
	logic wd_enable; // Watchdog may fire
	logic wd_timeout; // Watchdog expiry pulse
	logic wd_clear; // Service completed
	logic mon_enable; // Clock fail monitor enabled
	logic mon_fail; // Clock fail flag
	logic mon_ack; // Failure taken
	logic prot_open; // Protected bits writable now
	logic opt_wr; // Write to options register

	// Address match for a write or read
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Vector for a cause and mode
	function automatic logic [15:0] vec_of(input logic [1:0] c, input logic sp);
		case (c)
			rwcm_pkg::CAUSE_CLKFAIL: vec_of = sp ? rwcm_pkg::VEC_SP_CLKFAIL : rwcm_pkg::VEC_CLKFAIL;
			rwcm_pkg::CAUSE_WATCHDOG: vec_of = sp ? rwcm_pkg::VEC_SP_WATCHDOG :
				rwcm_pkg::VEC_WATCHDOG;
			default: vec_of = sp ? rwcm_pkg::VEC_SP_NORMAL : rwcm_pkg::VEC_NORMAL;
		endcase
	endfunction : vec_of

	////////////////////////////////////////////////////////////////////
	// Input synchronisers: pin, oscillator, IRQ, mode strap
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 4'h6;
			sync2_reg <= 4'h6;
		end else begin
			sync1_reg <= {special_mode, irq_n, reset_pin_in, osc_running};
			sync2_reg <= sync1_reg;
		end
	end

	assign osc_s = sync2_reg[0];
	assign pin_s = sync2_reg[1];
	assign irq_s = sync2_reg[2];
	assign special_s = sync2_reg[3];

	////////////////////////////////////////////////////////////////////
	// Reset sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= rwcm_pkg::ST_POR;
			seq_cnt_reg <= '0;
			cause_reg <= rwcm_pkg::CAUSE_NORMAL;
			reset_pin_oe <= 1'b0;
			cpu_reset <= 1'b1;
		end else begin
			case (state_reg)
				rwcm_pkg::ST_POR: begin
					// Count only once the oscillator runs
					if (osc_s) begin
						if (seq_cnt_reg == rwcm_pkg::POR_WAIT_CYC - 12'h001) begin
							state_reg <= rwcm_pkg::ST_HOLD;
							seq_cnt_reg <= '0;
						end else begin
							seq_cnt_reg <= seq_cnt_reg + 12'h001;
						end
					end
				end
				rwcm_pkg::ST_RUN: begin
					// Clock fail outranks watchdog, watchdog outranks pin
					if (mon_fail) begin
						cause_reg <= rwcm_pkg::CAUSE_CLKFAIL;
						state_reg <= rwcm_pkg::ST_DRIVE;
						reset_pin_oe <= 1'b1;
						cpu_reset <= 1'b1;
					end else if (wd_timeout) begin
						cause_reg <= rwcm_pkg::CAUSE_WATCHDOG;
						state_reg <= rwcm_pkg::ST_DRIVE;
						reset_pin_oe <= 1'b1;
						cpu_reset <= 1'b1;
					end else if (!pin_s) begin
						cause_reg <= rwcm_pkg::CAUSE_NORMAL;
						state_reg <= rwcm_pkg::ST_DRIVE;
						reset_pin_oe <= 1'b1;
						cpu_reset <= 1'b1;
					end
					seq_cnt_reg <= '0;
				end
				rwcm_pkg::ST_DRIVE: begin
					// Pin held low for a fixed count, then released
					if (seq_cnt_reg == rwcm_pkg::PIN_DRIVE_CYC - 12'h001) begin
						reset_pin_oe <= 1'b0;
						state_reg <= rwcm_pkg::ST_SETTLE;
						seq_cnt_reg <= '0;
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 12'h001;
					end
				end
				rwcm_pkg::ST_SETTLE: begin
					// Settle count plus synchroniser lag, so pin_s shows the pin
					// as it stood two cycles after release; low means external
					if (seq_cnt_reg == rwcm_pkg::PIN_SETTLE_CYC + rwcm_pkg::SYNC_DELAY_CYC -
						12'h001) begin
						if (!pin_s) begin
							cause_reg <= rwcm_pkg::CAUSE_NORMAL;
						end
						state_reg <= rwcm_pkg::ST_HOLD;
						seq_cnt_reg <= '0;
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 12'h001;
					end
				end
				rwcm_pkg::ST_HOLD: begin
					// Stay in reset while the pin is held low
					if (pin_s) begin
						state_reg <= rwcm_pkg::ST_RUN;
						cpu_reset <= 1'b0;
					end
				end
				default: begin
					state_reg <= rwcm_pkg::ST_POR;
					seq_cnt_reg <= '0;
					reset_pin_oe <= 1'b0;
					cpu_reset <= 1'b1;
				end
			endcase
		end
	end

	assign reset_pin_out = 1'b0;

	// Vector and cause captured as the CPU leaves reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reset_vector <= rwcm_pkg::VEC_NORMAL;
			last_cause <= rwcm_pkg::CAUSE_NORMAL;
		end else if (state_reg == rwcm_pkg::ST_HOLD && pin_s) begin
			reset_vector <= vec_of(cause_reg, special_s);
			last_cause <= cause_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Watchdog enable: configuration latched during reset only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wd_disable_reg <= 1'b1;
		end else if (cpu_reset) begin
			wd_disable_reg <= watchdog_disable_bit;
		end
	end

	// Reset inhibit test bit, set again by every reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inhibit_reg <= rwcm_pkg::TST_INHIBIT_RESET;
		end else if (cpu_reset) begin
			inhibit_reg <= rwcm_pkg::TST_INHIBIT_RESET;
		end else if (reg_wr && special_s && hit(reg_addr, rwcm_pkg::OFF_TEST_CONTROL)) begin
			inhibit_reg <= reg_wdata[rwcm_pkg::TST_INHIBIT];
		end
	end

	assign wd_enable = !wd_disable_reg && !(special_s && inhibit_reg);

	// Service sequence: 55 arms, AA clears only when armed
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arm_reg <= 1'b0;
		end else if (cpu_reset) begin
			arm_reg <= 1'b0;
		end else if (reg_wr && hit(reg_addr, rwcm_pkg::OFF_WATCHDOG_SERVICE)) begin
			if (reg_wdata == rwcm_pkg::SVC_ARM) begin
				arm_reg <= 1'b1;
			end else if (reg_wdata == rwcm_pkg::SVC_CLEAR) begin
				arm_reg <= 1'b0;
			end
		end
	end

	assign wd_clear = reg_wr && arm_reg && hit(reg_addr, rwcm_pkg::OFF_WATCHDOG_SERVICE) &&
		(reg_wdata == rwcm_pkg::SVC_CLEAR);

	rwcm_wdog u_wdog (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sys_reset(cpu_reset),
		.enable(wd_enable),
		.rate(option_reg[rwcm_pkg::OPT_RATE_HI:rwcm_pkg::OPT_RATE_LO]),
		.clear(wd_clear),
		.timeout(wd_timeout)
	);

	////////////////////////////////////////////////////////////////////
	// Clock fail monitor: forced bit keeps it on regardless of enable
	assign mon_enable = option_reg[rwcm_pkg::OPT_CFD_EN] ||
		option_reg[rwcm_pkg::OPT_CFD_FORCE];
	assign mon_ack = (state_reg == rwcm_pkg::ST_DRIVE);

	rwcm_clkmon u_clkmon (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.rc_stale(rc_stale),
		.stop_mode(stop_mode),
		.enable(mon_enable),
		.ack(mon_ack),
		.fail(mon_fail)
	);

	////////////////////////////////////////////////////////////////////
	// Protected write window after reset release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			win_cnt_reg <= '0;
			prot_done_reg <= 1'b0;
		end else if (cpu_reset) begin
			win_cnt_reg <= '0;
			prot_done_reg <= 1'b0;
		end else begin
			if (win_cnt_reg != rwcm_pkg::PROT_WINDOW_CYC) begin
				win_cnt_reg <= win_cnt_reg + 7'h01;
			end
			if (opt_wr) begin
				prot_done_reg <= 1'b1;
			end
		end
	end

	assign opt_wr = reg_wr && hit(reg_addr, rwcm_pkg::OFF_SYSTEM_OPTIONS);
	assign prot_open = special_s ||
		(win_cnt_reg != rwcm_pkg::PROT_WINDOW_CYC && !prot_done_reg);

	// Options register: free bits always, protected bits on the first write in the window or in special mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			option_reg <= rwcm_pkg::OPT_RESET;
		end else if (cpu_reset) begin
			option_reg <= rwcm_pkg::OPT_RESET;
		end else if (opt_wr) begin
			option_reg[rwcm_pkg::OPT_CONV_POWER] <= reg_wdata[rwcm_pkg::OPT_CONV_POWER];
			option_reg[rwcm_pkg::OPT_CONV_CLKSEL] <= reg_wdata[rwcm_pkg::OPT_CONV_CLKSEL];
			option_reg[rwcm_pkg::OPT_CFD_EN] <= reg_wdata[rwcm_pkg::OPT_CFD_EN];
			if (prot_open) begin
				option_reg[rwcm_pkg::OPT_IRQ_EDGE] <= reg_wdata[rwcm_pkg::OPT_IRQ_EDGE];
				option_reg[rwcm_pkg::OPT_STOP_DLY] <= reg_wdata[rwcm_pkg::OPT_STOP_DLY];
				option_reg[rwcm_pkg::OPT_RATE_HI] <= reg_wdata[rwcm_pkg::OPT_RATE_HI];
				option_reg[rwcm_pkg::OPT_RATE_LO] <= reg_wdata[rwcm_pkg::OPT_RATE_LO];
				// Forced bit can only be set; reset is the sole clear
				if (reg_wdata[rwcm_pkg::OPT_CFD_FORCE]) begin
					option_reg[rwcm_pkg::OPT_CFD_FORCE] <= 1'b1;
				end
			end
		end
	end

	assign converter_power_up = option_reg[rwcm_pkg::OPT_CONV_POWER];
	assign converter_clock_select = option_reg[rwcm_pkg::OPT_CONV_CLKSEL];

	////////////////////////////////////////////////////////////////////
	// IRQ sensing: falling edge pulse or low level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_q_reg <= 1'b1;
			irq_request <= 1'b0;
		end else begin
			irq_q_reg <= irq_s;
			if (option_reg[rwcm_pkg::OPT_IRQ_EDGE]) begin
				irq_request <= irq_q_reg && !irq_s;
			end else begin
				irq_request <= !irq_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// STOP exit: optional oscillator start-up delay
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stop_wait_reg <= 1'b0;
			stop_cnt_reg <= '0;
			stop_exit_ready <= 1'b0;
		end else if (stop_exit_req && !stop_wait_reg) begin
			if (option_reg[rwcm_pkg::OPT_STOP_DLY]) begin
				stop_wait_reg <= 1'b1;
				stop_cnt_reg <= '0;
				stop_exit_ready <= 1'b0;
			end else begin
				stop_exit_ready <= 1'b1;
			end
		end else if (stop_wait_reg) begin
			if (stop_cnt_reg == rwcm_pkg::STOP_DLY_CYC - 12'h001) begin
				stop_wait_reg <= 1'b0;
				stop_exit_ready <= 1'b1;
			end else begin
				stop_cnt_reg <= stop_cnt_reg + 12'h001;
				stop_exit_ready <= 1'b0;
			end
		end else begin
			stop_exit_ready <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register read port, data valid the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (hit(reg_addr, rwcm_pkg::OFF_SYSTEM_OPTIONS)) begin
				reg_rdata <= option_reg;
			end else if (hit(reg_addr, rwcm_pkg::OFF_TEST_CONTROL)) begin
				reg_rdata <= {7'h00, inhibit_reg};
			end else if (hit(reg_addr, rwcm_pkg::OFF_RESET_STATUS)) begin
				reg_rdata <= {4'h0, wd_enable, special_s, last_cause};
			end else begin
				reg_rdata <= '0; // Service and unmapped read zero
			end
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : rwcm_top

// ---- bench/rwcm_pin_model.sv ----
/* External reset circuit on the reset pin.
   Assumes a pull-up on the pin and a device that only drives it low. */
`timescale 1ns/100ps
module rwcm_pin_model (
	input wire logic pin_oe, // Device pulls the pin
	input wire logic pin_out, // Device drive value
	input wire logic ext_hold, // Supervisor holds the pin low
	output logic pin_level // Resolved pin level
);
	// Wired low with pull-up, a released pin reads high
	assign pin_level = !((pin_oe && !pin_out) || ext_hold);
endmodule : rwcm_pin_model

// ---- bench/rwcm_chk.sv ----
/* Port assertions of the reset sequencer.
   Assumes one clock and the asynchronous active low reset. */
`timescale 1ns/100ps
module rwcm_chk (
	input wire logic clk_sys, // Bus clock
	input wire logic rst_n, // Reset, active low
	input wire logic special_mode, // Mode strap
	input wire logic reset_pin_oe, // Pin drive enable
	input wire logic reset_pin_out, // Pin drive value
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic cpu_reset, // CPU held
	input wire logic [15:0] reset_vector, // Fetch vector
	input wire logic stop_exit_ready, // STOP exit pulse
	input wire logic converter_power_up, // Converter power
	input wire logic converter_clock_select, // Converter clock
	input wire logic [1:0] last_cause // Reset cause
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [12:0] por_cnt; // Cycles since reset release, saturating
	// Count cycles so the power-on wait can be bounded
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt <= 13'h0000;
		end else if (por_cnt != 13'h1fff) begin
			por_cnt <= por_cnt + 13'h0001;
		end
	end
	sequence s_drive;
		reset_pin_oe [*4] ##1 !reset_pin_oe;
	endsequence
	sequence s_settle;
		cpu_reset [*3];
	endsequence
	a_drive_four: assert property ($rose(reset_pin_oe) |-> s_drive)
		else $error("pin drive length wrong");
	a_pin_low: assert property (reset_pin_oe |-> !reset_pin_out)
		else $error("pin driven high");
	a_oe_holds_cpu: assert property (reset_pin_oe |-> cpu_reset)
		else $error("cpu runs while pin driven");
	a_settle_hold: assert property ($fell(reset_pin_oe) |-> s_settle)
		else $error("cpu released before pin sample");
	a_por_wait: assert property (!cpu_reset |-> por_cnt >= 13'h0fe0)
		else $error("cpu released before power-on wait");
	a_vec_cause: assert property ($fell(cpu_reset) |-> reset_vector ==
		{special_mode ? 8'hbf : 8'hff, last_cause == 2'h1 ? 8'hfc : last_cause == 2'h2 ? 8'hfa : 8'hfe})
		else $error("vector does not match cause");
	a_power_set: assert property ($rose(converter_power_up) |->
		$past(reg_wr && reg_addr == 8'h39 && reg_wdata[7])) else $error("power bit rose alone");
	a_clksel_set: assert property ($rose(converter_clock_select) |->
		$past(reg_wr && reg_addr == 8'h39 && reg_wdata[6])) else $error("clock bit rose alone");
	a_ready_pulse: assert property (stop_exit_ready |=> !stop_exit_ready)
		else $error("stop exit ready too long");
endmodule : rwcm_chk

bind rwcm_top rwcm_chk rwcm_chk_inst (.clk_sys, .rst_n, .special_mode, .reset_pin_oe,
	.reset_pin_out, .reg_addr, .reg_wdata, .reg_wr, .cpu_reset, .reset_vector,
	.stop_exit_ready, .converter_power_up, .converter_clock_select, .last_cause);

// ---- bench/tb_top.sv ----
/* Self-checking bench of the reset sequencer.
   Assumes the pin model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, osc_running = 1'b0; // Clock, reset, oscillator
	logic ext_hold = 1'b1, wd_off = 1'b1, rc_stale = 1'b0; // Supervisor, latch, RC
	logic stop_exit_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Wake and strobes
	logic irq_n = 1'b1, stop_mode = 1'b0; // IRQ pin, STOP state
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata; // Register port
	logic pin_level, reset_pin_out, reset_pin_oe, cpu_reset, stop_exit_ready; // Outputs
	logic irq_request, converter_power_up, converter_clock_select; // Outputs
	logic [15:0] reset_vector; // Fetch vector
	logic [1:0] last_cause; // Cause
	int err_total = 0, n_tests = 0, n; // Counters
	rwcm_top rwcm_top_inst (.clk_sys, .rst_n, .osc_running, .reset_pin_in(pin_level),
		.reset_pin_out, .reset_pin_oe, .special_mode(1'b0), .watchdog_disable_bit(wd_off),
		.irq_n, .stop_mode, .stop_exit_req, .rc_stale, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cpu_reset, .reset_vector, .irq_request,
		.stop_exit_ready, .converter_power_up, .converter_clock_select, .last_cause);
	rwcm_pin_model rwcm_pin_model_inst (.pin_oe(reset_pin_oe), .pin_out(reset_pin_out),
		.ext_hold, .pin_level);
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(16'(reg_rdata), 16'(exp));
	endtask : rd
	// Wait a bounded time for the CPU reset level
	task automatic wait_cpu(input logic lvl, input int lim);
		n = 0;
		while (cpu_reset !== lvl && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(16'(cpu_reset), 16'(lvl));
	endtask : wait_cpu
	task automatic chk_cause(input logic [1:0] c, input logic [15:0] v);
		check(16'(last_cause), 16'(c));
		check(reset_vector, v);
	endtask : chk_cause
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: power-on, options, STOP exit, clock fail, pin, watchdog
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		osc_running <= 1'b1;
		repeat (4200) @(posedge clk_sys);
		#1;
		check(16'(cpu_reset), 16'h0001);
		ext_hold <= 1'b0;
		wait_cpu(1'b0, 20);
		chk_cause(rwcm_pkg::CAUSE_NORMAL, rwcm_pkg::VEC_NORMAL);
		rd(8'h39, 8'h10);
		rd(8'h3d, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h39, 8'hff);
		rd(8'h39, 8'hff);
		check(16'({converter_power_up, converter_clock_select}), 16'h0003);
		irq_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check(16'(irq_request), 16'h0001);
		@(posedge clk_sys);
		#1;
		check(16'(irq_request), 16'h0000);
		irq_n <= 1'b1;
		wr(8'h39, 8'h00);
		rd(8'h39, 8'h37);
		check(16'({converter_power_up, converter_clock_select}), 16'h0000);
		$display("done: power-on and options");
		@(posedge clk_sys);
		stop_exit_req <= 1'b1;
		@(posedge clk_sys);
		stop_exit_req <= 1'b0;
		n = 0;
		while (stop_exit_ready !== 1'b1 && n < 4100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(16'(n >= 3990 && n <= 4010), 16'h0001);
		$display("done: stop exit delay");
		@(posedge clk_sys);
		wd_off <= 1'b0;
		rc_stale <= 1'b1;
		wait_cpu(1'b1, 10);
		rc_stale <= 1'b0;
		wait_cpu(1'b0, 40);
		chk_cause(rwcm_pkg::CAUSE_CLKFAIL, rwcm_pkg::VEC_CLKFAIL);
		rd(8'h3d, 8'h09);
		irq_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check(16'(irq_request), 16'h0001);
		irq_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		check(16'(irq_request), 16'h0000);
		repeat (70) @(posedge clk_sys);
		wr(8'h39, 8'h03);
		rd(8'h39, 8'h10);
		$display("done: clock fail");
		@(posedge clk_sys);
		ext_hold <= 1'b1;
		wait_cpu(1'b1, 10);
		repeat (20) @(posedge clk_sys);
		ext_hold <= 1'b0;
		wait_cpu(1'b0, 20);
		chk_cause(rwcm_pkg::CAUSE_NORMAL, rwcm_pkg::VEC_NORMAL);
		$display("done: pin reset");
		wr(8'h39, 8'h08);
		stop_mode <= 1'b1;
		wait_cpu(1'b1, 10);
		stop_mode <= 1'b0;
		wait_cpu(1'b0, 40);
		chk_cause(rwcm_pkg::CAUSE_CLKFAIL, rwcm_pkg::VEC_CLKFAIL);
		$display("done: stop with monitor on");
		wr(8'h3a, 8'h55);
		wr(8'h3a, 8'haa);
		wait_cpu(1'b1, 70000);
		check(16'(n >= 32768 && n <= 65540), 16'h0001);
		wait_cpu(1'b0, 40);
		chk_cause(rwcm_pkg::CAUSE_WATCHDOG, rwcm_pkg::VEC_WATCHDOG);
		$display("done: watchdog");
		tally_and_finish();
	end
	// Watchdog on the whole run, about a third above the expected length
	initial begin
		repeat (90000) @(posedge clk_sys);
		err_total++;
		tally_and_finish();
	end
endmodule : tb_top
